//--- hdl/tbt_pkg.sv
// shared constants and carrier types for the touch baseline/threshold block
package tbt_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_SENS = 2;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COMB_CFG0 = 8'h1c;
  localparam logic [7:0] ADDR_PICK0     = 8'h1e;
  localparam logic [7:0] ADDR_COMB_CFG1 = 8'h21;
  localparam logic [7:0] ADDR_PICK1     = 8'h23;
  localparam logic [7:0] ADDR_FREEZE    = 8'h4e;
  localparam logic [7:0] ADDR_BUCKET    = 8'h4f;
  localparam logic [7:0] ADDR_SETTLE    = 8'h50;
  localparam logic [7:0] ADDR_CLKREB    = 8'h51;
  localparam logic [7:0] ADDR_MARGIN    = 8'h52;
  localparam logic [7:0] ADDR_TOUCH0    = 8'h66;
  localparam logic [7:0] ADDR_TOUCH1    = 8'h67;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PICK0  = 8'h01;
  localparam logic [7:0] RST_PICK1  = 8'h02;
  localparam logic [7:0] RST_COMB   = 8'h00;
  localparam logic [7:0] RST_FREEZE = 8'h28;
  localparam logic [7:0] RST_BUCKET = 8'h64;
  localparam logic [7:0] RST_SETTLE = 8'ha0;
  localparam logic [7:0] RST_CLKREB = 8'h00;
  localparam logic [7:0] RST_MARGIN = 8'h0a;
  localparam logic [7:0] RST_TOUCH  = 8'h64;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int         COMB_EN_BIT  = 7;
  localparam int         COMB_INV_BIT = 1;
  localparam int         COMB_AND_BIT = 0;
  localparam int         REBASE_BIT   = 3;
  localparam int         CLKSEL_LSB   = 5;
  localparam int         CLKSEL_MSB   = 6;
  localparam logic [7:0] PICK_MASK    = 8'h03;
  localparam logic [7:0] COMB_MASK    = 8'h83;
  localparam logic [7:0] CLKREB_MASK  = 8'h68;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } tbt_wr_t;

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [7:0] settle_delay;
  } tbt_timing_t;

endpackage

//--- hdl/tbt_sense_timer.sv
// sense clock divider and conversion settling delay
`timescale 1ns/1ps
module tbt_sense_timer (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire tbt_pkg::tbt_timing_t timing_i,
  input  wire logic                 conv_start_i,
  output logic                      sense_tick_o,
  output logic                      conv_busy_o,
  output logic                      conv_done_o
);

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SETTLE = 2'b10} tbt_tmr_state_t;

  tbt_tmr_state_t state_reg;
  logic [2:0]     div_cnt_reg;
  logic [7:0]     settle_cnt_reg;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // mask of low counter bits that must all be set for one tick
  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'b00:   div_mask = 3'h0;
      2'b01:   div_mask = 3'h1;
      2'b10:   div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  // free-running count, tick when masked bits all high
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt_reg  <= 3'h0;
      sense_tick_o <= 1'b0;
    end
    else
    begin
      div_cnt_reg  <= div_cnt_reg + 3'h1;
      sense_tick_o <= (div_cnt_reg & div_mask(timing_i.clk_sel)) == div_mask(timing_i.clk_sel);
    end
  end

  // ----------------------------------------------------------------
  // settling hold
  // ----------------------------------------------------------------
  // holds the conversion for settle_delay sense ticks; a start while busy is ignored
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg      <= ST_IDLE;
      settle_cnt_reg <= 8'h00;
      conv_busy_o    <= 1'b0;
      conv_done_o    <= 1'b0;
    end
    else
    begin
      conv_done_o <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (conv_start_i)
          begin
            state_reg      <= ST_SETTLE;
            settle_cnt_reg <= timing_i.settle_delay;
            conv_busy_o    <= 1'b1;
          end
        end
        ST_SETTLE:
        begin
          if (sense_tick_o)
          begin
            if (settle_cnt_reg <= 8'h01)
            begin
              state_reg   <= ST_IDLE;
              conv_busy_o <= 1'b0;
              conv_done_o <= 1'b1;
            end
            else
            begin
              settle_cnt_reg <= settle_cnt_reg - 8'h01;
            end
          end
        end
        default:
        begin
          state_reg   <= ST_IDLE;
          conv_busy_o <= 1'b0;
        end
      endcase
    end
  end

  a_settle_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_reg == ST_IDLE && conv_start_i) |=> conv_busy_o && settle_cnt_reg == $past(timing_i.settle_delay))
    else $error("conversion did not start settling with programmed delay");

  a_div_full: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (timing_i.clk_sel == 2'b00) [*3] |-> sense_tick_o)
    else $error("undivided sense clock missed a tick");
endmodule

//--- hdl/tbt_touch_core.sv
// baseline tracking, hysteresis decision and output combiner for the touch channels
`timescale 1ns/1ps
// What this block does
// - pick registers hold a per-sensor mask feeding each output combiner; sensors only.
// - without auto rebase, samples at or above freeze level leave baseline alone.
// - positive difference below freeze level is added into the sensor bucket.
// - bucket reaching bucket limit bumps baseline by one and empties bucket.
// - conversion is held for the programmed settle delay, 1 to 255 sense ticks; 0 holds for 1.
// - settle delay and clock/rebase registers are writable only in setup mode.
// - two-bit sense clock code divides the fast oscillator by 1, 2, 4 or 8.
// - auto rebase set: every sample updates the baseline regardless of freeze level.
// - auto rebase clear: baseline moves only when difference is below freeze level.
// - inactive sensor turns on only when difference exceeds touch level plus margin.
// - active sensor turns off only when difference drops below touch level minus margin.
// - freeze, bucket, settle, rebase and margin settings are shared by all sensors.
// - combiner ORs selected states, ANDs when its operator bit is one, may invert.
// - each sensor has its own eight-bit touch level used by hysteresis.
module tbt_touch_core #(
  parameter int RAW_W = 16
) (
  input  wire logic                                     clk_i,
  input  wire logic                                     rst_b_i,
  input  wire logic                                     setup_mode_i,
  input  wire logic                                     reg_wr_i,
  input  wire tbt_pkg::tbt_wr_t                         reg_wr_data_i,
  input  wire logic [7:0]                               reg_rd_addr_i,
  input  wire logic                                     sample_valid_i,
  input  wire logic [tbt_pkg::NUM_SENS-1:0][RAW_W-1:0]  raw_count_i,
  input  wire logic                                     conv_start_i,
  output logic [7:0]                                    reg_rd_data_o,
  output logic [tbt_pkg::NUM_SENS-1:0]                  sensor_active_o,
  output logic [tbt_pkg::NUM_SENS-1:0]                  combine_out_o,
  output logic                                          sense_tick_o,
  output logic                                          conv_busy_o,
  output logic                                          conv_done_o
);

  localparam int N = tbt_pkg::NUM_SENS;

  logic       rst_meta_reg;
  logic       rst_n;
  logic [7:0] pick_reg      [N];
  logic [7:0] comb_cfg_reg  [N];
  logic [7:0] touch_reg     [N];
  logic [7:0] freeze_reg;
  logic [7:0] bucket_lim_reg;
  logic [7:0] settle_reg;
  logic [7:0] clkreb_reg;
  logic [7:0] margin_reg;
  logic [7:0] rd_next;
  logic       auto_rebase;
  logic [RAW_W-1:0] base_reg   [N];
  logic [7:0]       bucket_reg [N];

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // two-stage release so every flop leaves reset on the same edge
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // timing registers are locked outside setup so a running scan never sees them move
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pick_reg[0]     <= tbt_pkg::RST_PICK0;
      pick_reg[1]     <= tbt_pkg::RST_PICK1;
      comb_cfg_reg[0] <= tbt_pkg::RST_COMB;
      comb_cfg_reg[1] <= tbt_pkg::RST_COMB;
      touch_reg[0]    <= tbt_pkg::RST_TOUCH;
      touch_reg[1]    <= tbt_pkg::RST_TOUCH;
      freeze_reg      <= tbt_pkg::RST_FREEZE;
      bucket_lim_reg  <= tbt_pkg::RST_BUCKET;
      settle_reg      <= tbt_pkg::RST_SETTLE;
      clkreb_reg      <= tbt_pkg::RST_CLKREB;
      margin_reg      <= tbt_pkg::RST_MARGIN;
    end
    else if (reg_wr_i)
    begin
      case (reg_wr_data_i.addr)
        tbt_pkg::ADDR_PICK0:     pick_reg[0]     <= reg_wr_data_i.data & tbt_pkg::PICK_MASK;
        tbt_pkg::ADDR_PICK1:     pick_reg[1]     <= reg_wr_data_i.data & tbt_pkg::PICK_MASK;
        tbt_pkg::ADDR_COMB_CFG0: comb_cfg_reg[0] <= reg_wr_data_i.data & tbt_pkg::COMB_MASK;
        tbt_pkg::ADDR_COMB_CFG1: comb_cfg_reg[1] <= reg_wr_data_i.data & tbt_pkg::COMB_MASK;
        tbt_pkg::ADDR_TOUCH0:    touch_reg[0]    <= reg_wr_data_i.data;
        tbt_pkg::ADDR_TOUCH1:    touch_reg[1]    <= reg_wr_data_i.data;
        tbt_pkg::ADDR_FREEZE:    freeze_reg      <= reg_wr_data_i.data;
        tbt_pkg::ADDR_BUCKET:    bucket_lim_reg  <= reg_wr_data_i.data;
        tbt_pkg::ADDR_MARGIN:    margin_reg      <= reg_wr_data_i.data;
        tbt_pkg::ADDR_SETTLE:
        begin
          if (setup_mode_i)
            settle_reg <= reg_wr_data_i.data;
        end
        tbt_pkg::ADDR_CLKREB:
        begin
          if (setup_mode_i)
            clkreb_reg <= reg_wr_data_i.data & tbt_pkg::CLKREB_MASK;
        end
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    case (reg_rd_addr_i)
      tbt_pkg::ADDR_PICK0:     rd_next = pick_reg[0];
      tbt_pkg::ADDR_PICK1:     rd_next = pick_reg[1];
      tbt_pkg::ADDR_COMB_CFG0: rd_next = comb_cfg_reg[0];
      tbt_pkg::ADDR_COMB_CFG1: rd_next = comb_cfg_reg[1];
      tbt_pkg::ADDR_TOUCH0:    rd_next = touch_reg[0];
      tbt_pkg::ADDR_TOUCH1:    rd_next = touch_reg[1];
      tbt_pkg::ADDR_FREEZE:    rd_next = freeze_reg;
      tbt_pkg::ADDR_BUCKET:    rd_next = bucket_lim_reg;
      tbt_pkg::ADDR_SETTLE:    rd_next = settle_reg;
      tbt_pkg::ADDR_CLKREB:    rd_next = clkreb_reg;
      tbt_pkg::ADDR_MARGIN:    rd_next = margin_reg;
      default:                 rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      reg_rd_data_o <= 8'h00;
    else
      reg_rd_data_o <= rd_next;
  end

  assign auto_rebase = clkreb_reg[tbt_pkg::REBASE_BIT];

  a_setup_lock: assert property (@(posedge clk_i) disable iff (!rst_n)
    (reg_wr_i && !setup_mode_i && (reg_wr_data_i.addr == tbt_pkg::ADDR_SETTLE
      || reg_wr_data_i.addr == tbt_pkg::ADDR_CLKREB)) |=> $stable(settle_reg) && $stable(clkreb_reg))
    else $error("timing register changed outside setup mode");

  // ----------------------------------------------------------------
  // per-sensor baseline and decision
  // ----------------------------------------------------------------
  // raw minus baseline, clamped at zero
  function automatic logic [RAW_W-1:0] tbt_diff(input logic [RAW_W-1:0] raw, input logic [RAW_W-1:0] base);
    tbt_diff = (raw > base) ? raw - base : '0;
  endfunction

  for (genvar s = 0; s < N; s++)
  begin : g_sens
    logic [RAW_W-1:0] diff;
    logic             quiet;
    logic [8:0]       bucket_sum;
    logic [RAW_W-1:0] on_level;
    logic [RAW_W-1:0] off_level;

    assign diff       = tbt_diff(raw_count_i[s], base_reg[s]);
    assign quiet      = (diff != '0) && (diff < RAW_W'(freeze_reg));
    assign bucket_sum = {1'b0, bucket_reg[s]} + {1'b0, diff[7:0]};
    assign on_level   = RAW_W'({1'b0, touch_reg[s]} + {1'b0, margin_reg});
    assign off_level  = (touch_reg[s] > margin_reg) ? RAW_W'(touch_reg[s] - margin_reg) : '0;

    // baseline follows raw always in auto rebase, otherwise creeps up through the bucket
    always_ff @(posedge clk_i or negedge rst_n)
    begin
      if (!rst_n)
      begin
        base_reg[s]   <= '0;
        bucket_reg[s] <= 8'h00;
      end
      else if (sample_valid_i)
      begin
        if (auto_rebase)
        begin
          base_reg[s]   <= raw_count_i[s];
          bucket_reg[s] <= 8'h00;
        end
        else if (quiet)
        begin
          if (bucket_sum >= {1'b0, bucket_lim_reg})
          begin
            base_reg[s]   <= base_reg[s] + RAW_W'(1);
            bucket_reg[s] <= 8'h00;
          end
          else
            bucket_reg[s] <= bucket_sum[7:0];
        end
      end
    end

    // hysteresis keeps a hovering finger from chattering the output
    always_ff @(posedge clk_i or negedge rst_n)
    begin
      if (!rst_n)
        sensor_active_o[s] <= 1'b0;
      else if (sample_valid_i)
      begin
        if (!sensor_active_o[s] && diff > on_level)
          sensor_active_o[s] <= 1'b1;
        else if (sensor_active_o[s] && diff < off_level)
          sensor_active_o[s] <= 1'b0;
      end
    end

    a_noise_freeze: assert property (@(posedge clk_i) disable iff (!rst_n)
      (sample_valid_i && !auto_rebase && diff >= RAW_W'(freeze_reg)) |=> $stable(base_reg[s]))
      else $error("baseline moved on a noisy sample");

    a_auto_follow: assert property (@(posedge clk_i) disable iff (!rst_n)
      (sample_valid_i && auto_rebase) |=> base_reg[s] == $past(raw_count_i[s]))
      else $error("auto rebase did not take the raw count");

    a_bucket_bump: assert property (@(posedge clk_i) disable iff (!rst_n)
      (sample_valid_i && !auto_rebase && quiet && bucket_sum >= {1'b0, bucket_lim_reg})
      |=> base_reg[s] == $past(base_reg[s]) + RAW_W'(1) && bucket_reg[s] == 8'h00)
      else $error("full bucket did not bump baseline");

    a_bucket_fill: assert property (@(posedge clk_i) disable iff (!rst_n)
      (sample_valid_i && !auto_rebase && quiet && bucket_sum < {1'b0, bucket_lim_reg})
      |=> bucket_reg[s] == $past(bucket_sum[7:0]) && $stable(base_reg[s]))
      else $error("bucket did not accumulate difference");

    a_touch_on: assert property (@(posedge clk_i) disable iff (!rst_n)
      (!sensor_active_o[s] && !(sample_valid_i && diff > on_level)) |=> !sensor_active_o[s])
      else $error("sensor turned on below upper level");

    a_touch_off: assert property (@(posedge clk_i) disable iff (!rst_n)
      (sensor_active_o[s] && !(sample_valid_i && diff < off_level)) |=> sensor_active_o[s])
      else $error("sensor turned off above lower level");
  end

  // ----------------------------------------------------------------
  // output combiner
  // ----------------------------------------------------------------
  // disabled combiner drives low; an AND with nothing picked reads true
  function automatic logic tbt_combine(input logic [7:0] cfg, input logic [7:0] pick, input logic [N-1:0] act);
    logic r;
    r = 1'b0;
    if (cfg[tbt_pkg::COMB_AND_BIT])
      r = &(act | ~pick[N-1:0]);
    else
      r = |(act & pick[N-1:0]);
    tbt_combine = cfg[tbt_pkg::COMB_EN_BIT] & (r ^ cfg[tbt_pkg::COMB_INV_BIT]);
  endfunction

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      combine_out_o <= '0;
    else
      for (int k = 0; k < N; k++)
        combine_out_o[k] <= tbt_combine(comb_cfg_reg[k], pick_reg[k], sensor_active_o);
  end

  a_combine_or: assert property (@(posedge clk_i) disable iff (!rst_n)
    (comb_cfg_reg[1] == 8'h80) |=> combine_out_o[1] == |($past(sensor_active_o) & $past(pick_reg[1][N-1:0])))
    else $error("OR combiner mismatch");

  // ----------------------------------------------------------------
  // sense timing
  // ----------------------------------------------------------------
  tbt_sense_timer u_timer (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n),
    .timing_i     ({clkreb_reg[tbt_pkg::CLKSEL_MSB:tbt_pkg::CLKSEL_LSB], settle_reg}),
    .conv_start_i (conv_start_i),
    .sense_tick_o (sense_tick_o),
    .conv_busy_o  (conv_busy_o),
    .conv_done_o  (conv_done_o)
  );
endmodule

//--- verification/tbt_host_model.sv
// host side model: decoded register writes and registered reads
`timescale 1ns/1ps
module tbt_host_model (
  input  wire logic        clk_i,
  input  wire logic [7:0]  rd_data_i,
  output tbt_pkg::tbt_wr_t wr_data_o,
  output logic             wr_o,
  output logic [7:0]       rd_addr_o
);
  // idle levels from time zero so the core never sees an unknown strobe
  initial
  begin
    wr_o      = 1'b0;
    wr_data_o = '0;
    rd_addr_o = 8'h00;
  end

  // one-cycle strobe; the data is held through the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o      <= 1'b1;
    wr_data_o <= '{addr: a, data: d};
    @(posedge clk_i);
    wr_o      <= 1'b0;
  endtask

  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_addr_o <= a;
    @(posedge clk_i);
    #1 d = rd_data_i;
  endtask
endmodule

//--- verification/tbt_touch_core_tb.sv
// self-checking bench for the touch baseline and threshold core
`timescale 1ns/1ps
module tbt_touch_core_tb;
  logic                                clk_i          = 1'b0;
  logic                                rst_b_i        = 1'b0;
  logic                                setup_mode_i   = 1'b0;
  logic                                sample_valid_i = 1'b0;
  logic [tbt_pkg::NUM_SENS-1:0][15:0]  raw_count_i    = '0;
  logic                                conv_start_i   = 1'b0;
  logic                                reg_wr_i;
  tbt_pkg::tbt_wr_t                    reg_wr_data_i;
  logic [7:0]                          reg_rd_addr_i;
  logic [7:0]                          reg_rd_data_o;
  logic [1:0]                          sensor_active_o;
  logic [1:0]                          combine_out_o;
  logic                                sense_tick_o;
  logic                                conv_busy_o;
  logic                                conv_done_o;
  int                                  bad_count = 0;
  int                                  compares  = 0;
  logic [7:0]                          regs [256];
  int                                  base [2]  = '{0, 0};
  int                                  bkt [2]   = '{0, 0};
  logic [1:0]                          act       = 2'b00;
  logic [7:0]                          rdv;
  int                                  raws [14] = '{1200, 1095, 1089, 1110, 1111, 1050, 1037,
                                                     1039, 500, 1015, 1015, 1110, 1111, 1112};

  always #2.5 clk_i = ~clk_i;

  tbt_touch_core #(.RAW_W(16)) u_tbt_touch_core (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .setup_mode_i(setup_mode_i), .reg_wr_i(reg_wr_i),
    .reg_wr_data_i(reg_wr_data_i), .reg_rd_addr_i(reg_rd_addr_i), .sample_valid_i(sample_valid_i),
    .raw_count_i(raw_count_i), .conv_start_i(conv_start_i), .reg_rd_data_o(reg_rd_data_o),
    .sensor_active_o(sensor_active_o), .combine_out_o(combine_out_o), .sense_tick_o(sense_tick_o),
    .conv_busy_o(conv_busy_o), .conv_done_o(conv_done_o));

  tbt_host_model u_tbt_host_model (
    .clk_i(clk_i), .rd_data_i(reg_rd_data_o), .wr_data_o(reg_wr_data_i), .wr_o(reg_wr_i),
    .rd_addr_o(reg_rd_addr_i));

  // ------------------------------------------------------------
  // compare and closing tasks
  // ------------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk2(input string nm, input logic [1:0] e, input logic [1:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // register access with an expected-value shadow
  // ------------------------------------------------------------
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h1e, 8'h23: return 8'h03;
      8'h1c, 8'h21: return 8'h83;
      8'h51:        return 8'h68;
      8'h4e, 8'h4f, 8'h50, 8'h52, 8'h66, 8'h67: return 8'hff;
      default:      return 8'h00;
    endcase
  endfunction

  // timing registers only take writes in setup mode
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    u_tbt_host_model.wr(a, d);
    if (setup_mode_i || (a != 8'h50 && a != 8'h51))
      regs[a] = d & wmask(a);
  endtask

  // two unmapped places close the list; they must read zero
  task automatic check_regs();
    logic [7:0] al [13] = '{8'h1c, 8'h1e, 8'h21, 8'h23, 8'h4e, 8'h4f, 8'h50, 8'h51, 8'h52,
                            8'h66, 8'h67, 8'h40, 8'hff};
    foreach (al[i])
    begin
      u_tbt_host_model.rd(al[i], rdv);
      chk8($sformatf("reg_%h", al[i]), regs[al[i]], rdv);
    end
  endtask

  // ------------------------------------------------------------
  // sample path with a reference model of baseline and hysteresis
  // ------------------------------------------------------------
  function automatic logic [1:0] comb();
    logic [1:0] e;
    logic [7:0] c;
    logic [1:0] p;
    for (int k = 0; k < 2; k++)
    begin
      c    = k ? regs[8'h21] : regs[8'h1c];
      p    = k ? regs[8'h23][1:0] : regs[8'h1e][1:0];
      e[k] = c[7] & (c[1] ^ (c[0] ? &(act | ~p) : |(act & p)));
    end
    return e;
  endfunction

  task automatic sample(input int r);
    int         d;
    logic [7:0] t;
    logic [7:0] m;
    logic [1:0] e;
    @(posedge clk_i);
    sample_valid_i <= 1'b1;
    raw_count_i    <= {r[15:0], r[15:0]};
    m = regs[8'h52];
    for (int s = 0; s < 2; s++)
    begin
      t = regs[8'h66 + s];
      d = (r > base[s]) ? r - base[s] : 0;
      if (!act[s] && d > t + m)
        act[s] = 1'b1;
      else if (act[s] && t > m && d < t - m)
        act[s] = 1'b0;
      if (regs[8'h51][3])
      begin
        base[s] = r;
        bkt[s]  = 0;
      end
      else if (d > 0 && d < regs[8'h4e])
      begin
        bkt[s] = bkt[s] + d;
        if (bkt[s] >= regs[8'h4f])
        begin
          base[s] = base[s] + 1;
          bkt[s]  = 0;
        end
      end
    end
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    #1 chk2("sensor_active", act, sensor_active_o);
    e = comb();
    @(posedge clk_i);
    #1 chk2("combine_out", e, combine_out_o);
  endtask

  // ------------------------------------------------------------
  // sense divider and settling hold
  // ------------------------------------------------------------
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic settle(input logic [1:0] c);
    int gap;
    int ticks;
    cfg(8'h51, {1'b0, c, 5'h00});
    // let the new divider code reach the tick flop before hunting for a tick
    step();
    gap = 0;
    while (sense_tick_o !== 1'b1 && gap < 20)
    begin
      step();
      gap++;
    end
    gap = 0;
    do
    begin
      step();
      gap++;
    end
    while (sense_tick_o !== 1'b1 && gap < 20);
    chk8("tick_gap", 8'h01 << c, gap[7:0]);
    @(posedge clk_i);
    conv_start_i <= 1'b1;
    @(posedge clk_i);
    conv_start_i <= 1'b0;
    #1 ticks = 0;
    gap = 0;
    while (conv_done_o !== 1'b1 && gap < 200)
    begin
      if (sense_tick_o === 1'b1 && conv_busy_o === 1'b1)
        ticks++;
      step();
      gap++;
    end
    chk8("settle_ticks", regs[8'h50], ticks[7:0]);
    chk2("busy_done", 2'b01, {conv_busy_o, conv_done_o});
    step();
    chk2("done_pulse", 2'b00, {conv_busy_o, conv_done_o});
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    foreach (regs[i])
      regs[i] = 8'h00;
    regs[8'h1e] = 8'h01;
    regs[8'h23] = 8'h02;
    regs[8'h4e] = 8'h28;
    regs[8'h4f] = 8'h64;
    regs[8'h50] = 8'ha0;
    regs[8'h52] = 8'h0a;
    regs[8'h66] = 8'h64;
    regs[8'h67] = 8'h64;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check_regs();
    cfg(8'h50, 8'h05);
    cfg(8'h51, 8'hff);
    check_regs();
    @(posedge clk_i);
    setup_mode_i <= 1'b1;
    cfg(8'h50, 8'h02);
    cfg(8'h51, 8'hff);
    cfg(8'h4e, 8'h14);
    cfg(8'h4f, 8'h1e);
    cfg(8'h67, 8'h30);
    cfg(8'h1c, 8'hff);
    cfg(8'h21, 8'h80);
    cfg(8'h23, 8'hff);
    check_regs();
    sample(1000);
    sample(1000);
    cfg(8'h51, 8'h00);
    foreach (raws[i])
      sample(raws[i]);
    for (int c = 0; c < 4; c++)
      settle(c[1:0]);
    report_and_stop();
  end

  // the sequence needs under a thousand cycles; this limit is far beyond it
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule
